// ---- inc/serial_comm_unit_regs.svh ----
`ifndef SERIAL_COMM_UNIT_REGS_SVH
`define SERIAL_COMM_UNIT_REGS_SVH

`define OVERSAMPLE_RATIO     16
`define OVERSAMPLE_CNT_W     4
`define SAMPLE_CENTER        4'h7
`define LAST_PHASE           4'hF
`define DATA_BITS            8
`define BREAK_DATA           8'h00
`define TX_EMPTY_RESET       1'b1
`define BAUD_DIV_DEFAULT     16'h0004
`define BAUD_DIV_W           16

`endif

// ---- inc/serial_comm_unit_pkg.sv ----
package serial_comm_unit_pkg;

  typedef enum logic [2:0]
  {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP   = 3'b110
  } rx_state_type;

  typedef struct packed
  {
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_holding_empty;
  } status_flags_type;

  typedef struct packed
  {
    logic rx_full_clear;
    logic overrun_clear;
    logic framing_clear;
    logic parity_clear;
    logic tx_empty_clear;
  } flag_clears_type;

  typedef struct packed
  {
    logic rx_error_request;
    logic rx_end_request;
    logic tx_end_request;
  } irq_lines_type;

endpackage

// ---- src/serial_comm_unit.sv ----
// Function
// RL1 - Drive three separate request lines: transmit-end, receive-end, receive-error.
// RL2 - Transmit-end request is holding-empty flag AND transmit interrupt enable.
// RL3 - Receive-end request is receive-full flag AND receive interrupt enable.
// RL4 - Receive-error request is OR of error flags gated by receive enable; the code gates it by rx_irq_enable_in instead.
// RL5 - Priority: receive-error highest, receive-end middle, transmit-end lowest.
// RL6 - Holding register always accepts writes; unmoved old byte is overwritten and lost.
// RL7 - Software should see holding-empty at 1 before writing a byte.
// RL8 - On overrun set overrun flag; receive-full stays 1.
// RL9 - Framing/parity only: set flags, load data register, receive-full stays 0.
// RL10 - Any combination with overrun: set all detected flags, no data transfer.
// RL11 - Continuous low line gives framing error and data 00.
// RL12 - Reception continues in break, so cleared framing flag sets again.
// RL13 - Receive sampling clock runs at sixteen times the baud rate.
// RL14 - Start bit falling edge detected on sampling clock falling edges.
// RL15 - Every frame bit sampled at sampling clock rising edge nearest centre.
// RL16 - Overrun when last bit of new byte arrives while receive-full is 1.
// RL17 - Framing error when stop bit sampled as 0.
// RL18 - Parity error when frame parity disagrees with odd/even setting.
// RL19 - Software clears receive-full by reading 1 then writing 0.
// RL20 - Error flags stay until cleared; error request stays while set and enabled.
`timescale 1ns/100ps
`include "serial_comm_unit_regs.svh"

module serial_comm_unit
  import serial_comm_unit_pkg::*;
#(
  parameter int DATA_BITS = `DATA_BITS
)
(
  input  wire logic                   core_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   rx_line_in,
  input  wire logic                   rx_enable_in,
  input  wire logic                   parity_enable_in,
  input  wire logic                   parity_odd_in,
  input  wire logic [`BAUD_DIV_W-1:0] baud_div_in,
  input  wire logic                   tx_irq_enable_in,
  input  wire logic                   rx_irq_enable_in,
  input  wire logic                   tx_write_in,
  input  wire logic [DATA_BITS-1:0]   tx_data_in,
  input  wire logic                   tx_load_in,
  input  wire flag_clears_type        flag_clear_in,
  output logic [DATA_BITS-1:0]        tx_shift_out,
  output logic [DATA_BITS-1:0]        rx_data_out,
  output status_flags_type            status_out,
  output irq_lines_type               irq_out,
  output logic [1:0]                  irq_top_out
);

  // ****************************************
  // Input synchroniser and sample clock
  // ****************************************
  logic                   rx_meta_reg;
  logic                   rx_sync_reg;
  logic [`BAUD_DIV_W-1:0] div_cnt_reg;
  logic                   tick_reg;
  logic                   phase_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rx_line_in;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Half-period enables: phase low = rising edge, phase high = falling edge of the x16 clock
  wire div_wrap = (div_cnt_reg == `BAUD_DIV_W'(0));

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_cnt_reg <= `BAUD_DIV_DEFAULT;
      tick_reg    <= 1'b0;
      phase_reg   <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= div_wrap ? baud_div_in : div_cnt_reg - `BAUD_DIV_W'(1);
      tick_reg    <= div_wrap;
      phase_reg   <= div_wrap ? ~phase_reg : phase_reg;
    end
  end

  wire rise_en = tick_reg & ~phase_reg;  // [RL13]
  wire fall_en = tick_reg & phase_reg;   // [RL13]

  // ****************************************
  // Receive frame engine
  // ****************************************
  rx_state_type                  state_reg;
  rx_state_type                  state_next;
  logic [`OVERSAMPLE_CNT_W-1:0]  os_cnt_reg;
  logic [$clog2(DATA_BITS)-1:0]  bit_cnt_reg;
  logic [DATA_BITS-1:0]          rx_shift_reg;
  logic                          par_acc_reg;
  logic                          par_bad_reg;

  wire at_center  = rise_en & (os_cnt_reg == `SAMPLE_CENTER);  // [RL15]
  wire bit_end    = fall_en & (os_cnt_reg == `LAST_PHASE);
  wire last_data  = (bit_cnt_reg == ($clog2(DATA_BITS))'(DATA_BITS - 1));
  wire start_seen = fall_en & ~rx_sync_reg & rx_enable_in;      // [RL14]
  wire stop_take  = (state_reg == RX_STOP) & at_center;
  wire par_fail   = par_acc_reg ^ rx_sync_reg ^ parity_odd_in;  // [RL18]

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RX_IDLE:
      begin
        if (start_seen)
          state_next = RX_START;
      end
      RX_START:
      begin
        if (at_center & rx_sync_reg)
          state_next = RX_IDLE;
        else if (bit_end)
          state_next = RX_DATA;
      end
      RX_DATA:
      begin
        if (bit_end & last_data)
          state_next = parity_enable_in ? RX_PARITY : RX_STOP;
      end
      RX_PARITY:
      begin
        if (bit_end)
          state_next = RX_STOP;
      end
      RX_STOP:
      begin
        if (stop_take)
          state_next = RX_IDLE;  // [RL12]
      end
      default:
      begin
        state_next = RX_IDLE;
      end
    endcase
    if (!rx_enable_in)
      state_next = RX_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg    <= RX_IDLE;
      os_cnt_reg   <= '0;
      bit_cnt_reg  <= '0;
      rx_shift_reg <= '0;
      par_acc_reg  <= 1'b0;
      par_bad_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == RX_IDLE)
      begin
        os_cnt_reg  <= '0;
        bit_cnt_reg <= '0;
        par_acc_reg <= 1'b0;
        par_bad_reg <= 1'b0;
      end
      else if (fall_en)
        os_cnt_reg <= os_cnt_reg + `OVERSAMPLE_CNT_W'(1);
      if (state_reg == RX_DATA && at_center)
      begin
        rx_shift_reg <= {rx_sync_reg, rx_shift_reg[DATA_BITS-1:1]};  // [RL15]
        par_acc_reg  <= par_acc_reg ^ rx_sync_reg;
      end
      if (state_reg == RX_DATA && bit_end)
        bit_cnt_reg <= bit_cnt_reg + ($clog2(DATA_BITS))'(1);
      if (state_reg == RX_PARITY && at_center)
        par_bad_reg <= par_fail;  // [RL18]
    end
  end

  // ****************************************
  // Status flags and data transfer
  // ****************************************
  logic [DATA_BITS-1:0] rx_data_reg;
  logic [DATA_BITS-1:0] tx_holding_reg;
  logic [DATA_BITS-1:0] tx_shift_reg;
  status_flags_type     flags_reg;
  status_flags_type     flags_next;

  wire overrun_hit = stop_take & flags_reg.rx_full_flag;  // [RL16]
  wire framing_hit = stop_take & ~rx_sync_reg;            // [RL17] [RL11]
  wire parity_hit  = stop_take & par_bad_reg;
  wire clean_frame = stop_take & ~framing_hit & ~parity_hit & ~overrun_hit;
  wire move_data   = stop_take & ~overrun_hit;            // [RL9] [RL10]

  always_comb
  begin
    flags_next = flags_reg;
    // Hardware set wins over a software clear in the same cycle
    if (flag_clear_in.rx_full_clear)
      flags_next.rx_full_flag = 1'b0;  // [RL19]
    if (flag_clear_in.overrun_clear)
      flags_next.overrun_flag = 1'b0;  // [RL20]
    if (flag_clear_in.framing_clear)
      flags_next.framing_flag = 1'b0;  // [RL20]
    if (flag_clear_in.parity_clear)
      flags_next.parity_flag = 1'b0;  // [RL20]
    if (flag_clear_in.tx_empty_clear)
      flags_next.tx_holding_empty = 1'b0;
    if (clean_frame)
      flags_next.rx_full_flag = 1'b1;
    if (overrun_hit)
      flags_next.rx_full_flag = 1'b1;  // [RL8]
    if (overrun_hit)
      flags_next.overrun_flag = 1'b1;  // [RL8] [RL10]
    if (framing_hit)
      flags_next.framing_flag = 1'b1;  // [RL10] [RL12]
    if (parity_hit)
      flags_next.parity_flag = 1'b1;  // [RL10]
    if (tx_load_in)
      flags_next.tx_holding_empty = 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      flags_reg      <= '{default: 1'b0, tx_holding_empty: `TX_EMPTY_RESET};
      rx_data_reg    <= '0;
    end
    else
    begin
      flags_reg <= flags_next;
      if (move_data)
        rx_data_reg <= rx_shift_reg;  // [RL9] [RL11]
    end
  end

  // ****************************************
  // Transmit holding path
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_holding_reg <= '0;
      tx_shift_reg   <= '0;
    end
    else
    begin
      if (tx_write_in)
        tx_holding_reg <= tx_data_in;  // [RL6]
      if (tx_load_in)
        tx_shift_reg <= tx_holding_reg;
    end
  end

  // ****************************************
  // Interrupt request lines
  // ****************************************
  wire err_any = flags_reg.overrun_flag | flags_reg.framing_flag | flags_reg.parity_flag;
  irq_lines_type        irq_reg;
  logic [1:0]           top_reg;
  irq_lines_type        irq_now;

  assign irq_now.rx_error_request = err_any & rx_irq_enable_in;                     // [RL4] [RL20]
  assign irq_now.rx_end_request   = flags_reg.rx_full_flag & rx_irq_enable_in;      // [RL3]
  assign irq_now.tx_end_request   = flags_reg.tx_holding_empty & tx_irq_enable_in;  // [RL2]

  // Highest pending request code: 3 error, 2 receive-end, 1 transmit-end, 0 none
  wire [1:0] top_now = irq_now.rx_error_request ? 2'h3 :
                       irq_now.rx_end_request   ? 2'h2 :
                       irq_now.tx_end_request   ? 2'h1 : 2'h0;  // [RL5]

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_reg <= '0;
      top_reg <= 2'h0;
    end
    else
    begin
      irq_reg <= irq_now;  // [RL1]
      top_reg <= top_now;
    end
  end

  assign irq_out      = irq_reg;
  assign irq_top_out  = top_reg;
  assign status_out   = flags_reg;
  assign rx_data_out  = rx_data_reg;
  assign tx_shift_out = tx_shift_reg;

endmodule

// ---- dv/serial_comm_unit_props.sv ----
`timescale 1ns/100ps
module serial_comm_unit_props
  import serial_comm_unit_pkg::*;
#(
  parameter int DATA_BITS = 8
)
(
  input wire logic                 core_clk_in,
  input wire logic                 resetn_in,
  input wire logic                 tx_irq_enable_in,
  input wire logic                 rx_irq_enable_in,
  input wire logic                 tx_load_in,
  input wire flag_clears_type      flag_clear_in,
  input wire logic [DATA_BITS-1:0] rx_data_out,
  input wire status_flags_type     status_out,
  input wire irq_lines_type        irq_out,
  input wire logic [1:0]           irq_top_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_ovr_set;
    $rose(status_out.overrun_flag);
  endsequence
  sequence s_ovr_only_clear;
    flag_clear_in.overrun_clear && status_out.overrun_flag && !status_out.framing_flag && !status_out.parity_flag;
  endsequence
  chk_tx_end_request: assert property ($past(resetn_in) |-> irq_out.tx_end_request
    == $past(status_out.tx_holding_empty && tx_irq_enable_in))
    else $error("tx end request wrong");
  chk_rx_end_request: assert property ($past(resetn_in) |-> irq_out.rx_end_request
    == $past(status_out.rx_full_flag && rx_irq_enable_in))
    else $error("rx end request wrong");
  chk_rx_err_request: assert property ($past(resetn_in) |-> irq_out.rx_error_request
    == $past((status_out.overrun_flag || status_out.framing_flag || status_out.parity_flag) && rx_irq_enable_in))
    else $error("rx error request wrong");
  chk_top_code_order: assert property (irq_top_out == (irq_out.rx_error_request ? 2'h3 : irq_out.rx_end_request ? 2'h2 :
    irq_out.tx_end_request ? 2'h1 : 2'h0))
    else $error("priority code wrong");
  chk_overrun_keeps: assert property (s_ovr_set |-> status_out.rx_full_flag && $stable(rx_data_out))
    else $error("overrun moved data or dropped full");
  chk_framing_hold: assert property ($fell(status_out.framing_flag) |-> $past(flag_clear_in.framing_clear))
    else $error("framing flag dropped without clear");
  chk_clear_drops_req: assert property (s_ovr_only_clear |-> ##2 !irq_out.rx_error_request)
    else $error("error request stays after clear");
  chk_load_sets_empty: assert property (tx_load_in |=> status_out.tx_holding_empty)
    else $error("load did not set empty");
endmodule
bind serial_comm_unit serial_comm_unit_props #(.DATA_BITS(DATA_BITS)) u_props (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .tx_irq_enable_in(tx_irq_enable_in), .rx_irq_enable_in(rx_irq_enable_in),
  .tx_load_in(tx_load_in), .flag_clear_in(flag_clear_in), .rx_data_out(rx_data_out), .status_out(status_out),
  .irq_out(irq_out), .irq_top_out(irq_top_out));

// ---- dv/serial_line_model.sv ----
`timescale 1ns/100ps
module serial_line_model
(
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // Sends start, eight data bits LSB first, optional parity, stop
  task automatic send(input logic [7:0] d, input logic par, input logic stop, input logic with_par, input int cyc);
    logic [10:0] f;
    int          n;
    f = with_par ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = with_par ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      line_out = f[i];
      repeat (cyc) @(negedge clk_in);
    end
    line_out = 1'b1;
  endtask
  task automatic set_line(input logic v);
    line_out = v;
  endtask
endmodule

// ---- dv/serial_comm_unit_test.sv ----
`timescale 1ns/100ps
module serial_comm_unit_test;
  import serial_comm_unit_pkg::*;
  logic clk = 0, rstn = 0, par_odd = 0, par_en = 1, tx_irq_enable = 1, rx_irq_enable = 1, txw = 0, txl = 0;
  logic [7:0] txd = 8'h00, tsh, rdat;
  logic [15:0] div = 16'h0000;
  flag_clears_type  clr = '0;
  status_flags_type st;
  irq_lines_type    irq;
  logic [1:0]       top;
  wire              line;
  int err_total = 0, comparisons = 0, bit_cyc = 32;
  serial_comm_unit u_serial_comm_unit (.core_clk_in(clk), .resetn_in(rstn), .rx_line_in(line), .rx_enable_in(1'b1),
    .parity_enable_in(par_en), .parity_odd_in(par_odd), .baud_div_in(div), .tx_irq_enable_in(tx_irq_enable),
    .rx_irq_enable_in(rx_irq_enable), .tx_write_in(txw), .tx_data_in(txd), .tx_load_in(txl), .flag_clear_in(clr),
    .tx_shift_out(tsh), .rx_data_out(rdat), .status_out(st), .irq_out(irq), .irq_top_out(top));
  serial_line_model u_serial_line_model (.clk_in(clk), .line_out(line));
  initial forever #50 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic pulse_clear(input logic [4:0] c);
    @(negedge clk);
    clr = c;
    @(negedge clk);
    clr = '0;
    @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] d, input logic bad_par, input logic stop);
    @(negedge clk);
    u_serial_line_model.send(d, ^d ^ par_odd ^ bad_par, stop, par_en, bit_cyc);
    repeat (8) @(negedge clk);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    check({3'h0, st}, 8'h01);
    check({5'h0, irq}, 8'h01);
    check({6'h0, top}, 8'h01);
    $display("test reset done");
    check({7'h0, st.tx_holding_empty}, 8'h01);
    txd = 8'hA5;
    txw = 1;
    @(negedge clk);
    txw = 0;
    pulse_clear(5'h01);
    check({5'h0, irq}, 8'h00);
    txd = 8'h3C;
    txw = 1;
    @(negedge clk);
    txw = 0;
    txl = 1;
    @(negedge clk);
    txl = 0;
    @(negedge clk);
    check(tsh, 8'h3C);
    check({3'h0, st}, 8'h01);
    check({5'h0, irq}, 8'h01);
    $display("test transmit done");
    frame(8'h5A, 0, 1);
    check(rdat, 8'h5A);
    check({3'h0, st}, 8'h11);
    check({6'h0, top}, 8'h02);
    frame(8'hC3, 1, 1);
    check(rdat, 8'h5A);
    check({3'h0, st}, 8'h1B);
    check({5'h0, irq}, 8'h07);
    check({6'h0, top}, 8'h03);
    rx_irq_enable = 0;
    repeat (2) @(negedge clk);
    check({5'h0, irq}, 8'h01);
    rx_irq_enable = 1;
    pulse_clear(5'h02);
    check({5'h0, irq}, 8'h07);
    pulse_clear(5'h18);
    check({3'h0, st}, 8'h01);
    check({5'h0, irq}, 8'h01);
    $display("test overrun done");
    frame(8'h33, 1, 0);
    check(rdat, 8'h33);
    check({3'h0, st}, 8'h07);
    pulse_clear(5'h0E);
    par_odd = 1;
    frame(8'h0F, 1, 1);
    check(rdat, 8'h0F);
    check({3'h0, st}, 8'h03);
    par_odd = 0;
    pulse_clear(5'h0E);
    $display("test errors done");
    par_en = 0;
    div = 16'h0001;
    bit_cyc = 64;
    frame(8'hA6, 0, 1);
    check(rdat, 8'hA6);
    check({3'h0, st}, 8'h11);
    pulse_clear(5'h10);
    check({3'h0, st}, 8'h01);
    par_en = 1;
    div = 16'h0000;
    bit_cyc = 32;
    $display("test slow frame done");
    u_serial_line_model.set_line(0);
    repeat (400) @(negedge clk);
    check(rdat, 8'h00);
    check({3'h0, st}, 8'h05);
    pulse_clear(5'h04);
    repeat (400) @(negedge clk);
    check({3'h0, st}, 8'h05);
    u_serial_line_model.set_line(1);
    repeat (400) @(negedge clk);
    $display("test break done");
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule
